// ---- fault_mgr_regs.vh ----
// What this block does
// (RULE_01) config: tracking en, phase en, six latch selects
// (RULE_02) select one latches, zero retries; phase ignored
// (RULE_03) non-latching trip retries start every 130 ms
// (RULE_04) latching stays off until clear plus 130 ms
// (RULE_05) warnings never shut the converter down
// (RULE_06) temp warning above 120C, released below 117C
// (RULE_07) power-good report only when enabled
// (RULE_08) power good low outside 110%/90-95% window
// (RULE_09) power good checked in steady state only
// (RULE_10) power good warning clears status bit, restores
// (RULE_11) external low on power good is warning
// (RULE_12) any fault-class trip shuts converter off
// (RULE_13) overcurrent below undervoltage level: fast off
// (RULE_14) host should keep current-limit temperature compensation
// (RULE_15) undervoltage in steady state: regular ramp-down
// (RULE_16) overtemperature always active above 120C, regular off
// (RULE_17) non-latching overtemperature restarts below 110C
// (RULE_18) tracking deviation over 250 mV during ramp: fast off
// (RULE_19) overvoltage: high side off, low side on
// (RULE_20) overvoltage level 110-130% but at least 1.0 V
// (RULE_21) phase voltage error not implemented
// (RULE_22) local fault may propagate to other converters
// (RULE_23) 130 ms counted on clock from zero output
`ifndef FAULT_MGR_REGS_VH
`define FAULT_MGR_REGS_VH
`define PTC_RESET        8'h47
`define PTC_TRACK_EN     7
`define PTC_PHASE_EN     6
`define PTC_TR_LATCH     5
`define PTC_OT_LATCH     4
`define PTC_OC_LATCH     3
`define PTC_UV_LATCH     2
`define PTC_OV_LATCH     1
`define PTC_PH_LATCH     0
`define PRC_RESET        8'h3F
`define PRC_TEMP_MSG     7
`define PRC_PG_MSG       6
`define ST_TEMPW         6
`define ST_PG            5
`define ST_OC            4
`define ST_UV            3
`define ST_OT            2
`define ST_TR            1
`define ST_OV            0
`define ST_RESET         7'h7F
`define CLK_HZ           10000000
`define RESTART_MS       130
`define RESTART_CYCLES   (`RESTART_MS * (`CLK_HZ / 1000))
`define TEMP_WARN_ON_C   120
`define TEMP_WARN_OFF_C  117
`define TEMP_RESTART_C   110
`define TRACK_LIMIT_MV   250
`define OV_FLOOR_MV      1000
`endif

// ---- restart_timer.v ----
`include "fault_mgr_regs.vh"
module restart_timer #(
  parameter CYCLES = `RESTART_CYCLES,
  parameter W      = 21
) (
  // clock and reset
  input  wire clk_in,
  input  wire reset_n_in,
  // control
  input  wire start_in,
  output wire done_out
);
  reg [W-1:0] count_reg;
  reg         run_reg;
  reg         done_reg;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count_reg <= {W{1'b0}};
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else if (start_in) begin
      count_reg <= {W{1'b0}};
      run_reg   <= 1'b1;
      done_reg  <= 1'b0;
    end else if (run_reg) begin
      if (count_reg == CYCLES[W-1:0] - 1'b1) begin // [RULE_23]
        run_reg  <= 1'b0;
        done_reg <= 1'b1;
      end
      count_reg <= count_reg + 1'b1;
    end
  end
  assign done_out = done_reg;
endmodule // restart_timer

// ---- voltage_window.v ----
`include "fault_mgr_regs.vh"
module voltage_window #(
  parameter VW = 12
) (
  // clock and reset
  input  wire          clk_in,
  input  wire          reset_n_in,
  // measurements in millivolts, power good and overvoltage level selects
  input  wire [VW-1:0] vout_mv_in,
  input  wire [VW-1:0] vset_mv_in,
  input  wire [VW-1:0] vref_ramp_mv_in,
  input  wire          pg_low_95_in,
  input  wire [1:0]    ov_level_in,
  // compare results
  output reg           pg_outside_out,
  output reg           ov_over_out,
  output reg           track_dev_out
);
  function [VW+7:0] pct;
    input [VW-1:0] v;
    input [7:0]    p;
    pct = v * p;
  endfunction
  wire [VW+7:0] vout100  = vout_mv_in * 8'h64;
  wire [VW+7:0] pg_hi    = pct(vset_mv_in, 8'h6E);
  wire [VW+7:0] pg_lo    = pct(vset_mv_in, pg_low_95_in ? 8'h5F : 8'h5A);
  wire [7:0]    ov_pct   = (ov_level_in == 2'h0) ? 8'h6E :
                           (ov_level_in == 2'h1) ? 8'h78 : 8'h82;
  wire [VW+7:0] ov_raw   = pct(vset_mv_in, ov_pct);
  localparam [31:0] OV_FLOOR = `OV_FLOOR_MV * 100;
  wire [VW+7:0] ov_floor = OV_FLOOR[VW+7:0];
  wire [VW+7:0] ov_lvl   = (ov_raw < ov_floor) ? ov_floor : ov_raw; // [RULE_20]
  wire [VW:0]   diff     = (vout_mv_in > vref_ramp_mv_in) ?
                           {1'b0, vout_mv_in - vref_ramp_mv_in} :
                           {1'b0, vref_ramp_mv_in - vout_mv_in};
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pg_outside_out <= 1'b0;
      ov_over_out    <= 1'b0;
      track_dev_out  <= 1'b0;
    end else begin
      pg_outside_out <= (vout100 > pg_hi) || (vout100 < pg_lo); // [RULE_08]
      ov_over_out    <= vout100 > ov_lvl;
      track_dev_out  <= diff > `TRACK_LIMIT_MV; // [RULE_18]
    end
  end
endmodule // voltage_window

// ---- fault_manager.v ----
`include "fault_mgr_regs.vh"
module fault_manager #(
  parameter VW             = 12,
  parameter RESTART_CYCLES = `RESTART_CYCLES
) (
  // clock and reset
  input  wire          clk_in,
  input  wire          reset_n_in,
  // register access from serial interface
  input  wire          ptc_wr_in,
  input  wire [7:0]    ptc_wdata_in,
  input  wire          prc_wr_in,
  input  wire [7:0]    prc_wdata_in,
  input  wire          st_clear_wr_in,
  input  wire [6:0]    st_clear_mask_in,
  input  wire          pg_low_95_in,
  input  wire [1:0]    ov_level_in,
  output reg  [7:0]    protection_type_config_out,
  output reg  [7:0]    propagation_report_config_out,
  output reg  [6:0]    protection_status_out,
  // converter state
  input  wire          turn_on_in,
  input  wire          steady_state_in,
  input  wire          ramping_up_in,
  input  wire          above_prebias_in,
  input  wire          output_at_zero_in,
  input  wire          current_limit_in,
  input  wire          below_uv_in,
  input  wire signed [9:0] temp_c_in,
  input  wire [VW-1:0] vout_mv_in,
  input  wire [VW-1:0] vset_mv_in,
  input  wire [VW-1:0] vref_ramp_mv_in,
  // power good open-drain pin
  input  wire          power_good_in,
  output wire          power_good_output_out,
  output wire          power_good_oe_out,
  // converter control
  output reg           enable_out,
  output reg           fast_off_out,
  output reg           low_side_on_out,
  // reports and propagation
  output reg           temp_warning_msg_out,
  output reg           power_good_msg_out,
  output reg           propagate_out
);
  localparam S_RUN  = 4'b0001;
  localparam S_OFF  = 4'b0010;
  localparam S_WAIT = 4'b0100;
  localparam S_HOLD = 4'b1000;

  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg        latched_reg;
  reg        temp_warn_reg;
  reg        turn_on_d_reg;
  reg  [6:0] cause_reg;
  wire       pg_outside;
  wire       ov_over;
  wire       track_dev;
  wire       timer_done;
  wire       timer_start = (state_reg == S_OFF) && output_at_zero_in; // [RULE_23]

  voltage_window #(.VW(VW)) u_window (
    .clk_in          (clk_in),
    .reset_n_in      (reset_n_in),
    .vout_mv_in      (vout_mv_in),
    .vset_mv_in      (vset_mv_in),
    .vref_ramp_mv_in (vref_ramp_mv_in),
    .pg_low_95_in    (pg_low_95_in),
    .ov_level_in     (ov_level_in),
    .pg_outside_out  (pg_outside),
    .ov_over_out     (ov_over),
    .track_dev_out   (track_dev)
  );

  restart_timer #(.CYCLES(RESTART_CYCLES)) u_timer (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .start_in   (timer_start),
    .done_out   (timer_done)
  );

  wire [7:0] ptc = protection_type_config_out;
  // detection conditions; phase error never raised [RULE_21]
  wire oc_det = above_prebias_in && current_limit_in && below_uv_in; // [RULE_13]
  wire uv_det = steady_state_in && below_uv_in && !oc_det; // [RULE_15]
  wire ot_det = temp_c_in > 10'sd120; // [RULE_16]
  wire tr_det = ptc[`PTC_TRACK_EN] && ramping_up_in && track_dev; // [RULE_18]
  wire ov_det = above_prebias_in && ov_over; // [RULE_19]
  wire fault  = state_reg == S_RUN && (oc_det || uv_det || ot_det || tr_det || ov_det);
  wire fast   = oc_det || tr_det; // [RULE_13] [RULE_18]
  wire latch_sel = (oc_det && ptc[`PTC_OC_LATCH]) || (uv_det && ptc[`PTC_UV_LATCH]) ||
                   (ot_det && ptc[`PTC_OT_LATCH]) || (tr_det && ptc[`PTC_TR_LATCH]) ||
                   (ov_det && ptc[`PTC_OV_LATCH]); // [RULE_02]
  wire cause_gone = !(cause_reg[`ST_OC] && oc_det) && !(cause_reg[`ST_UV] && uv_det) &&
                    !(cause_reg[`ST_TR] && tr_det) && !(cause_reg[`ST_OV] && ov_det) &&
                    !(cause_reg[`ST_OT] && temp_c_in >= 10'sd110); // [RULE_17]
  wire turn_on_cycled = turn_on_in && !turn_on_d_reg;
  wire st_cleared = st_clear_wr_in && |(st_clear_mask_in & cause_reg);

  // power good: held low outside steady state, sensed externally too
  wire pg_drive_low = !steady_state_in || pg_outside; // [RULE_09] [RULE_08]
  assign power_good_output_out = 1'b0;
  assign power_good_oe_out     = pg_drive_low;
  wire pg_warn = steady_state_in && (pg_outside || !power_good_in); // [RULE_11]

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_RUN:  if (fault) state_next = S_OFF; // [RULE_12]
      S_OFF:  if (output_at_zero_in) state_next = S_WAIT;
      S_WAIT: if (timer_done) state_next = S_HOLD;
      S_HOLD: if (cause_gone && (!latched_reg || st_cleared || turn_on_cycled))
                state_next = S_RUN; // [RULE_03] [RULE_04]
      default: state_next = S_RUN;
    endcase
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg     <= S_RUN;
      latched_reg   <= 1'b0;
      temp_warn_reg <= 1'b0;
      turn_on_d_reg <= 1'b0;
      cause_reg     <= 7'h00;
      protection_type_config_out    <= `PTC_RESET;
      propagation_report_config_out <= `PRC_RESET;
      protection_status_out         <= `ST_RESET;
      enable_out           <= 1'b0;
      fast_off_out         <= 1'b0;
      low_side_on_out      <= 1'b0;
      temp_warning_msg_out <= 1'b0;
      power_good_msg_out   <= 1'b0;
      propagate_out        <= 1'b0;
    end else begin
      state_reg     <= state_next;
      turn_on_d_reg <= turn_on_in;
      if (ptc_wr_in)
        protection_type_config_out <= ptc_wdata_in; // [RULE_01]
      if (prc_wr_in)
        propagation_report_config_out <= prc_wdata_in;
      // temperature warning hysteresis, never shuts down
      if (temp_c_in > 10'sd120)
        temp_warn_reg <= 1'b1; // [RULE_06] [RULE_05]
      else if (temp_c_in < 10'sd117)
        temp_warn_reg <= 1'b0;
      if (fault) begin
        latched_reg <= latch_sel;
        cause_reg   <= {2'b00, oc_det, uv_det, ot_det, tr_det, ov_det};
      end else if (state_next == S_RUN && state_reg == S_HOLD) begin
        cause_reg <= 7'h00;
      end
      // status: zero means flagged; hardware set wins over clear
      protection_status_out[`ST_TEMPW] <= !temp_warn_reg; // [RULE_06]
      protection_status_out[`ST_PG]    <= !pg_warn; // [RULE_10]
      if (fault) begin
        protection_status_out[4:0] <= protection_status_out[4:0] &
          ~{oc_det, uv_det, ot_det, tr_det, ov_det};
      end else if (st_clear_wr_in) begin
        protection_status_out[4:0] <= protection_status_out[4:0] | st_clear_mask_in[4:0];
      end
      enable_out      <= turn_on_in && (state_next == S_RUN);
      if (fault) begin
        fast_off_out    <= fast || ov_det; // [RULE_19]
        low_side_on_out <= ov_det; // [RULE_19]
      end else if (state_next == S_RUN) begin
        fast_off_out    <= 1'b0;
        low_side_on_out <= 1'b0;
      end
      temp_warning_msg_out <= temp_warn_reg && propagation_report_config_out[`PRC_TEMP_MSG];
      power_good_msg_out   <= pg_warn && propagation_report_config_out[`PRC_PG_MSG]; // [RULE_07]
      propagate_out <= (state_next != S_RUN) &&
        |(cause_reg[4:0] & {propagation_report_config_out[3], propagation_report_config_out[2],
          propagation_report_config_out[4], propagation_report_config_out[5],
          propagation_report_config_out[1]}); // [RULE_22]
    end
  end
endmodule // fault_manager

// ---- converter_stage_model.sv ----
module converter_stage_model (
  input  wire clk_in,
  input  wire reset_n_in,
  input  wire enable_in,
  output wire steady_state_out,
  output wire ramping_up_out,
  output wire above_prebias_out,
  output wire output_at_zero_out
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [2:0] level_reg;
  // ramps up in steps while enabled and back down to zero when disabled
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) level_reg <= 3'h0;
    else if (enable_in && level_reg != 3'h4) level_reg <= level_reg + 3'h1;
    else if (!enable_in && level_reg != 3'h0) level_reg <= level_reg - 3'h1;
  end
  assign steady_state_out   = enable_in && level_reg == 3'h4;
  assign ramping_up_out     = enable_in && level_reg != 3'h4;
  assign above_prebias_out  = level_reg != 3'h0;
  assign output_at_zero_out = level_reg == 3'h0;
endmodule // converter_stage_model

// ---- pol_fault_monitor.sv ----
module pol_fault_monitor (
  input wire              clk_in,
  input wire              reset_n_in,
  input wire              ptc_wr_in,
  input wire [7:0]        ptc_wdata_in,
  input wire              steady_state_in,
  input wire              turn_on_in,
  input wire signed [9:0] temp_c_in,
  input wire [7:0]        protection_type_config_out,
  input wire [7:0]        propagation_report_config_out,
  input wire [6:0]        protection_status_out,
  input wire              power_good_output_out,
  input wire              power_good_oe_out,
  input wire              enable_out,
  input wire              fast_off_out,
  input wire              low_side_on_out,
  input wire              temp_warning_msg_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_ptc_write_lands: assert property (ptc_wr_in |=>
    protection_type_config_out == $past(ptc_wdata_in)) else $error("config write lost");
  a_pg_transition_low: assert property (!steady_state_in |-> power_good_oe_out)
    else $error("power good not low in transition");
  a_pg_never_high: assert property (!power_good_output_out)
    else $error("power good pin driven high");
  a_warn_no_off: assert property ($fell(enable_out) && $past(turn_on_in) |->
    protection_status_out[4:0] != 5'h1F) else $error("shutdown with no fault flag");
  a_ov_low_side: assert property ($fell(protection_status_out[0]) |->
    ##[0:1] low_side_on_out && !enable_out) else $error("overvoltage without low side on");
  a_oc_fast_off: assert property ($fell(protection_status_out[4]) |-> ##[0:1] fast_off_out)
    else $error("overcurrent without fast off");
  a_temp_msg_gate: assert property (temp_warning_msg_out |->
    propagation_report_config_out[7] || $past(propagation_report_config_out[7]))
    else $error("temp message while disabled");
  a_hot_flags: assert property ((temp_c_in > 10'sd120)[*3] |->
    !protection_status_out[6] && !enable_out) else $error("hot without warning or off");
  a_cool_clears: assert property ((temp_c_in < 10'sd117)[*3] |-> protection_status_out[6])
    else $error("temp warning kept when cool");
endmodule // pol_fault_monitor
bind fault_manager pol_fault_monitor mon_u (.clk_in, .reset_n_in, .ptc_wr_in, .ptc_wdata_in,
  .steady_state_in, .turn_on_in, .temp_c_in, .protection_type_config_out,
  .propagation_report_config_out, .protection_status_out, .power_good_output_out,
  .power_good_oe_out, .enable_out, .fast_off_out, .low_side_on_out, .temp_warning_msg_out);

// ---- pol_protection_fault_manager_tb_top.sv ----
module pol_protection_fault_manager_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC = 20;
  logic clk_in = 1'b0, reset_n_in = 1'b0, turn_on = 1'b0, ext_low = 1'b0;
  logic ptc_wr = 1'b0, prc_wr = 1'b0, clr_wr = 1'b0, cur_lim = 1'b0, below_uv = 1'b0;
  logic [7:0] ptc_d = 8'h00, prc_d = 8'h00;
  logic [6:0] clr_m = 7'h00;
  logic signed [9:0] temp = 10'sd25;
  logic [11:0] vout = 12'h3E8;
  logic [11:0] trk = 12'h000;
  logic pg95 = 1'b0;
  logic [1:0] ovl = 2'h0;
  wire [7:0] ptc_q, prc_q;
  wire [6:0] st;
  wire pg_o, pg_oe, en, fast, lows, tmsg, pmsg, prop, steady, ramp, prebias, zero;
  wire pg_wire = !(pg_oe || ext_low);
  int fail_count = 0, checked = 0, n;
  always #50 clk_in = ~clk_in;
  fault_manager #(.VW(12), .RESTART_CYCLES(RC)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .ptc_wr_in(ptc_wr), .ptc_wdata_in(ptc_d), .prc_wr_in(prc_wr), .prc_wdata_in(prc_d),
    .st_clear_wr_in(clr_wr), .st_clear_mask_in(clr_m), .pg_low_95_in(pg95), .ov_level_in(ovl),
    .protection_type_config_out(ptc_q), .propagation_report_config_out(prc_q),
    .protection_status_out(st), .turn_on_in(turn_on), .steady_state_in(steady),
    .ramping_up_in(ramp), .above_prebias_in(prebias), .output_at_zero_in(zero),
    .current_limit_in(cur_lim), .below_uv_in(below_uv), .temp_c_in(temp), .vout_mv_in(vout),
    .vset_mv_in(12'h3E8), .vref_ramp_mv_in(vout + trk), .power_good_in(pg_wire),
    .power_good_output_out(pg_o), .power_good_oe_out(pg_oe), .enable_out(en),
    .fast_off_out(fast), .low_side_on_out(lows), .temp_warning_msg_out(tmsg),
    .power_good_msg_out(pmsg), .propagate_out(prop));
  converter_stage_model stage_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .enable_in(en),
    .steady_state_out(steady), .ramping_up_out(ramp), .above_prebias_out(prebias),
    .output_at_zero_out(zero));
  task automatic cyc(input int c); repeat (c) @(negedge clk_in); endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wait_en(input logic v);
    for (int i = 0; i < 300 && en !== v; i++) cyc(1);
    chk("enable", {7'h00, v}, {7'h00, en});
  endtask
  task automatic wait_up();
    for (int i = 0; i < 300 && steady !== 1'b1; i++) cyc(1);
    cyc(3);
  endtask
  // sel 0 type config, 1 report config, 2 status clear
  task automatic wr(input int sel, input logic [7:0] d);
    cyc(1);
    ptc_d = d; prc_d = d; clr_m = d[6:0];
    ptc_wr = sel == 0; prc_wr = sel == 1; clr_wr = sel == 2;
    cyc(1);
    ptc_wr = 1'b0; prc_wr = 1'b0; clr_wr = 1'b0;
  endtask
  task automatic t_regs();
    chk("type cfg", 8'h47, ptc_q);
    chk("report cfg", 8'h3F, prc_q);
    chk("status", 8'h7F, {1'b0, st});
    wr(0, 8'hA5);
    chk("type cfg wr", 8'hA5, ptc_q);
    wr(0, 8'h47);
    $display("test regs done");
  endtask
  task automatic t_pg();
    vout = 12'h320; cyc(4);
    chk("pg oe low", 8'h01, {7'h00, pg_oe});
    chk("pg bit", 8'h00, {7'h00, st[5]});
    chk("pg msg off", 8'h00, {7'h00, pmsg});
    chk("enable", 8'h01, {7'h00, en});
    vout = 12'h442; cyc(4);
    chk("pg in window", 8'h20, {1'b0, st & 7'h20} | {7'h00, pg_oe});
    ext_low = 1'b1; cyc(4);
    chk("pg forced", 8'h00, {7'h00, st[5]});
    ext_low = 1'b0; vout = 12'h3E8; cyc(4);
    $display("test pg done");
  endtask
  task automatic t_ov();
    vout = 12'h47E; wait_en(1'b0);
    chk("ov flags", 8'h02, {lows, st[0]});
    vout = 12'h3E8; cyc(3 * RC);
    chk("ov latched", 8'h00, {7'h00, en});
    wr(2, 8'h01); wait_en(1'b1); wait_up();
    $display("test ov done");
  endtask
  task automatic t_ot();
    wr(1, 8'hFF); temp = 10'sd121; wait_en(1'b0); cyc(2);
    chk("ot flags", 8'h01, {1'b0, st[6], st[2], tmsg});
    chk("propagate", 8'h01, {7'h00, prop});
    temp = 10'sd115; cyc(3 * RC);
    chk("ot cool", 8'h02, {6'h00, st[6], en});
    temp = 10'sd105; wait_en(1'b1); wait_up();
    ext_low = 1'b1;
    cyc(3);
    chk("pg msg on", 8'h01, {7'h00, pmsg});
    ext_low = 1'b0;
    cyc(3);
    $display("test ot done");
  endtask
  task automatic t_uv();
    wr(0, 8'h43); below_uv = 1'b1; wait_en(1'b0);
    chk("uv flags", 8'h00, {fast, st[3]});
    for (int i = 0; i < 300 && zero !== 1'b1; i++) cyc(1);
    for (n = 0; n < 300 && en !== 1'b1; n++) cyc(1);
    chk("retry gap", 8'h01, {7'h00, n >= RC - 1 && n <= RC + 5});
    below_uv = 1'b0; wr(2, 8'h08); wait_up();
    cur_lim = 1'b1; below_uv = 1'b1; wait_en(1'b0);
    chk("oc flags", 8'h05, {fast, st[4], st[3]});
    cur_lim = 1'b0; below_uv = 1'b0;
    $display("test uv oc done");
  endtask
  task automatic t_lvl();
    pg95 = 1'b1;
    vout = 12'h3AC;
    cyc(4);
    chk("pg 95 low", 8'h01, {7'h00, pg_oe});
    pg95 = 1'b0;
    cyc(4);
    chk("pg 90 low", 8'h00, {7'h00, pg_oe});
    ovl = 2'h2;
    vout = 12'h47E;
    cyc(4);
    chk("ov at 130", 8'h03, {6'h00, en, pg_oe});
    ovl = 2'h0;
    vout = 12'h3E8;
    cyc(4);
    $display("test levels done");
  endtask
  task automatic t_tr();
    wr(0, 8'hA3);
    trk = 12'h12C;
    wait_en(1'b1);
    wait_en(1'b0);
    chk("tr flags", 8'h02, {fast, st[1]});
    trk = 12'h000;
    cyc(3 * RC);
    chk("tr latched", 8'h00, {7'h00, en});
    turn_on = 1'b0;
    cyc(2);
    turn_on = 1'b1;
    wait_en(1'b1);
    $display("test tr done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #500us;
    fail_count++;
    $display("MISMATCH watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    cyc(20);
    reset_n_in = 1'b1;
    cyc(2);
    t_regs();
    turn_on = 1'b1;
    wait_up();
    t_pg();
    t_lvl();
    t_ov();
    t_ot();
    t_uv();
    t_tr();
    finish_test();
  end
endmodule // pol_protection_fault_manager_tb_top
